// file: core/scan_tap.sv
// Boundary-scan test port: controller, instruction decode, scan paths, pad mux.
// Assumes TCK from the board tester, ball logic on CLK, pads resolved outside.
//
// Functional notes
// R01: EXTEST 0x00 captures ball ring, boundary register sits between TDI and TDO.
// R02: Under EXTEST the balls are driven from the boundary update cells.
// R03: IDCODE 0x21 loads the ID register, selects it, normal operation stays.
// R04: SAMPLE/PRELOAD 0x05 captures ring, selects boundary path, normal operation stays.
// R05: CLAMP 0x07 selects bypass while balls drive boundary register values.
// R06: HIGH-Z 0x03 selects bypass and floats every ball output.
// R07: BYPASS 0xff selects the one-bit bypass, normal operation untouched.
// R08: Instruction register is eight bits; Capture-IR loads its two LSBs with 01.
// R09: Instruction becomes IDCODE at power-up and in Test-Logic-Reset.
// R10: Boundary register is 113 bits, MSB at TDI, LSB at TDO.
// R11: ID register is 32 bits, loaded with its fixed code at Capture-DR.
// R12: Tester loads only the six defined codes; others are reserved.
module scan_tap #(
  parameter int          BSR_W   = tap_pkg::BSR_W,
  parameter logic [31:0] ID_CODE = tap_pkg::ID_DEFAULT
) (
  input  wire logic             CLK,
  input  wire logic             RST_N,
  input  wire logic             TCK,
  input  wire logic             TMS,
  input  wire logic             TDI,
  output logic                  TDO,
  output logic                  TDO_OE_N,
  input  wire logic [BSR_W-1:0] BALL_I,
  input  wire logic [BSR_W-1:0] CORE_O,
  input  wire logic [BSR_W-1:0] CORE_OE_N,
  output logic      [BSR_W-1:0] BALL_O,
  output logic      [BSR_W-1:0] BALL_OE_N
);

  logic                  rst_t1_r;
  logic                  rst_t2_r;
  logic                  tck_rst_n;
  tap_pkg::tap_st_t      st_r;
  tap_pkg::tap_st_t      st_nxt;
  logic [7:0]            ir_r;
  logic [7:0]            ir_nxt;
  logic [7:0]            ir_sh_r;
  logic [7:0]            ir_sh_nxt;
  logic [BSR_W-1:0]      ring1_r;
  logic [BSR_W-1:0]      ring_r;
  logic [BSR_W-1:0]      bsr_sh_r;
  logic [BSR_W-1:0]      bsr_sh_nxt;
  logic [BSR_W-1:0]      upd_r;
  logic [BSR_W-1:0]      upd_nxt;
  logic [31:0]           id_sh_r;
  logic [31:0]           id_sh_nxt;
  logic                  byp_r;
  logic                  byp_nxt;
  logic                  sel_bsr;
  logic                  sel_id;
  tap_pkg::pad_mode_t    mode_t_r;
  tap_pkg::pad_mode_t    mode_t_nxt;
  logic                  xfer_r;
  logic                  xfer_nxt;
  logic                  tdo_mux;
  logic                  tdo_r;
  logic                  tdo_oe_n_r;
  logic                  tg1_r;
  logic                  tg2_r;
  logic                  tg3_r;
  tap_pkg::pad_mode_t    mode_c_r;
  tap_pkg::pad_mode_t    mode_c_nxt;
  logic [BSR_W-1:0]      upd_c_r;
  logic [BSR_W-1:0]      upd_c_nxt;
  logic [BSR_W-1:0]      ball_o_r;
  logic [BSR_W-1:0]      ball_o_nxt;
  logic [BSR_W-1:0]      ball_oe_n_r;
  logic [BSR_W-1:0]      ball_oe_n_nxt;

  // Reset for the TCK side: asserts at once, releases on TCK
  always_ff @(posedge TCK or negedge RST_N) begin
    if (!RST_N) begin
      rst_t1_r <= 1'b0;
      rst_t2_r <= 1'b0;
    end else begin
      rst_t1_r <= 1'b1;
      rst_t2_r <= rst_t1_r;
    end
  end
  assign tck_rst_n = rst_t2_r;

  // Test port controller
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      tap_pkg::TLR:    st_nxt = TMS ? tap_pkg::TLR    : tap_pkg::RTI;
      tap_pkg::RTI:    st_nxt = TMS ? tap_pkg::SEL_DR : tap_pkg::RTI;
      tap_pkg::SEL_DR: st_nxt = TMS ? tap_pkg::SEL_IR : tap_pkg::CAP_DR;
      tap_pkg::CAP_DR: st_nxt = TMS ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
      tap_pkg::SH_DR:  st_nxt = TMS ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
      tap_pkg::EX1_DR: st_nxt = TMS ? tap_pkg::UPD_DR : tap_pkg::PAU_DR;
      tap_pkg::PAU_DR: st_nxt = TMS ? tap_pkg::EX2_DR : tap_pkg::PAU_DR;
      tap_pkg::EX2_DR: st_nxt = TMS ? tap_pkg::UPD_DR : tap_pkg::SH_DR;
      tap_pkg::UPD_DR: st_nxt = TMS ? tap_pkg::SEL_DR : tap_pkg::RTI;
      tap_pkg::SEL_IR: st_nxt = TMS ? tap_pkg::TLR    : tap_pkg::CAP_IR;
      tap_pkg::CAP_IR: st_nxt = TMS ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
      tap_pkg::SH_IR:  st_nxt = TMS ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
      tap_pkg::EX1_IR: st_nxt = TMS ? tap_pkg::UPD_IR : tap_pkg::PAU_IR;
      tap_pkg::PAU_IR: st_nxt = TMS ? tap_pkg::EX2_IR : tap_pkg::PAU_IR;
      tap_pkg::EX2_IR: st_nxt = TMS ? tap_pkg::UPD_IR : tap_pkg::SH_IR;
      tap_pkg::UPD_IR: st_nxt = TMS ? tap_pkg::SEL_DR : tap_pkg::RTI;
      default:         st_nxt = tap_pkg::TLR;
    endcase
  end

  // Instruction register
  always_comb begin
    ir_nxt    = ir_r;
    ir_sh_nxt = ir_sh_r;
    case (st_r)
      tap_pkg::TLR: begin
        ir_nxt = tap_pkg::OP_IDCODE; // see R09
      end
      tap_pkg::CAP_IR: begin
        ir_sh_nxt = {tap_pkg::IR_CAP_MSB, tap_pkg::IR_CAP_LSB}; // see R08
      end
      tap_pkg::SH_IR: begin
        ir_sh_nxt = {TDI, ir_sh_r[7:1]};
      end
      tap_pkg::UPD_IR: begin
        ir_nxt = ir_sh_r;
      end
      default: begin
        ir_nxt = ir_r;
      end
    endcase
  end

  // Reserved codes fall back to bypass with pads in normal use
  assign sel_bsr = (ir_r == tap_pkg::OP_EXTEST) || (ir_r == tap_pkg::OP_SAMPLE); // see R01, R04
  assign sel_id  = (ir_r == tap_pkg::OP_IDCODE); // see R03

  // Data registers
  always_comb begin
    bsr_sh_nxt = bsr_sh_r;
    upd_nxt    = upd_r;
    id_sh_nxt  = id_sh_r;
    byp_nxt    = byp_r;
    case (st_r)
      tap_pkg::CAP_DR: begin
        if (sel_bsr) begin
          bsr_sh_nxt = ring_r; // see R01, R04
        end
        if (sel_id) begin
          id_sh_nxt = ID_CODE; // see R11
        end
        byp_nxt = 1'b0;
      end
      tap_pkg::SH_DR: begin
        if (sel_bsr) begin
          bsr_sh_nxt = {TDI, bsr_sh_r[BSR_W-1:1]}; // see R10
        end
        if (sel_id) begin
          id_sh_nxt = {TDI, id_sh_r[31:1]}; // see R03
        end
        byp_nxt = TDI; // see R05, R06, R07
      end
      tap_pkg::UPD_DR: begin
        if (sel_bsr) begin
          upd_nxt = bsr_sh_r;
        end
      end
      default: begin
        byp_nxt = byp_r;
      end
    endcase
  end

  // Pad mode follows the instruction that is about to take effect
  always_comb begin
    case (ir_nxt)
      tap_pkg::OP_EXTEST: mode_t_nxt = tap_pkg::PAD_SCAN; // see R02
      tap_pkg::OP_CLAMP:  mode_t_nxt = tap_pkg::PAD_SCAN; // see R05
      tap_pkg::OP_HIGHZ:  mode_t_nxt = tap_pkg::PAD_HIZ; // see R06
      default:            mode_t_nxt = tap_pkg::PAD_FUNC; // see R03, R04, R07
    endcase
    xfer_nxt = xfer_r ^ ((ir_nxt != ir_r) || (upd_nxt != upd_r));
  end

  always_ff @(posedge TCK or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      st_r     <= tap_pkg::TLR;
      ir_r     <= tap_pkg::OP_IDCODE;
      ir_sh_r  <= 8'h00;
      ring1_r  <= '0;
      ring_r   <= '0;
      bsr_sh_r <= '0;
      upd_r    <= '0;
      id_sh_r  <= 32'h0000_0000;
      byp_r    <= 1'b0;
      mode_t_r <= tap_pkg::PAD_FUNC;
      xfer_r   <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      ir_r     <= ir_nxt;
      ir_sh_r  <= ir_sh_nxt;
      ring1_r  <= BALL_I;
      ring_r   <= ring1_r;
      bsr_sh_r <= bsr_sh_nxt;
      upd_r    <= upd_nxt;
      id_sh_r  <= id_sh_nxt;
      byp_r    <= byp_nxt;
      mode_t_r <= mode_t_nxt;
      xfer_r   <= xfer_nxt;
    end
  end

  // TDO changes on the falling edge so the tester samples it mid-bit
  always_comb begin
    if (st_r == tap_pkg::SH_IR) begin
      tdo_mux = ir_sh_r[0];
    end else if (sel_bsr) begin
      tdo_mux = bsr_sh_r[0]; // see R10
    end else if (sel_id) begin
      tdo_mux = id_sh_r[0];
    end else begin
      tdo_mux = byp_r;
    end
  end

  always_ff @(negedge TCK or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      tdo_r      <= 1'b0;
      tdo_oe_n_r <= 1'b1;
    end else begin
      tdo_r      <= tdo_mux;
      tdo_oe_n_r <= !((st_r == tap_pkg::SH_IR) || (st_r == tap_pkg::SH_DR));
    end
  end
  assign TDO      = tdo_r;
  assign TDO_OE_N = tdo_oe_n_r;

  // Ball side on CLK: words are copied after a toggle crossing, held many CLK cycles.
  always_comb begin
    mode_c_nxt    = mode_c_r;
    upd_c_nxt     = upd_c_r;
    if (tg2_r ^ tg3_r) begin
      mode_c_nxt = mode_t_r;
      upd_c_nxt  = upd_r;
    end
    case (mode_c_r)
      tap_pkg::PAD_SCAN: begin
        ball_o_nxt    = upd_c_r; // see R02, R05
        ball_oe_n_nxt = '0;
      end
      tap_pkg::PAD_HIZ: begin
        ball_o_nxt    = ball_o_r;
        ball_oe_n_nxt = '1; // see R06
      end
      default: begin
        ball_o_nxt    = CORE_O;
        ball_oe_n_nxt = CORE_OE_N;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tg1_r       <= 1'b0;
      tg2_r       <= 1'b0;
      tg3_r       <= 1'b0;
      mode_c_r    <= tap_pkg::PAD_FUNC;
      upd_c_r     <= '0;
      ball_o_r    <= '0;
      ball_oe_n_r <= '1;
    end else begin
      tg1_r       <= xfer_r;
      tg2_r       <= tg1_r;
      tg3_r       <= tg2_r;
      mode_c_r    <= mode_c_nxt;
      upd_c_r     <= upd_c_nxt;
      ball_o_r    <= ball_o_nxt;
      ball_oe_n_r <= ball_oe_n_nxt;
    end
  end
  assign BALL_O    = ball_o_r;
  assign BALL_OE_N = ball_oe_n_r;

  chk_extest_capture: assert property ( // see R01
    @(posedge TCK) disable iff (!tck_rst_n)
    (st_r == tap_pkg::CAP_DR && ir_r == tap_pkg::OP_EXTEST) |=> (bsr_sh_r == $past(ring_r))
  ) else $error("EXTEST capture missed the ball ring");

  chk_sample_capture: assert property ( // see R04
    @(posedge TCK) disable iff (!tck_rst_n)
    (st_r == tap_pkg::CAP_DR && ir_r == tap_pkg::OP_SAMPLE) |=> (bsr_sh_r == $past(ring_r))
  ) else $error("SAMPLE capture missed the ball ring");

  chk_id_capture: assert property ( // see R03, R11
    @(posedge TCK) disable iff (!tck_rst_n)
    (st_r == tap_pkg::CAP_DR && ir_r == tap_pkg::OP_IDCODE) |=> (id_sh_r == ID_CODE)
  ) else $error("ID register not loaded with its code");

  chk_ir_capture: assert property ( // see R08
    @(posedge TCK) disable iff (!tck_rst_n)
    (st_r == tap_pkg::CAP_IR) |=> (ir_sh_r[1:0] == 2'h1)
  ) else $error("Capture-IR pattern wrong");

  chk_reset_idcode: assert property ( // see R09
    @(posedge TCK) disable iff (!tck_rst_n)
    (st_r == tap_pkg::TLR) |=> (ir_r == tap_pkg::OP_IDCODE)
  ) else $error("Instruction not IDCODE after reset state");

  chk_bsr_shift: assert property ( // see R10
    @(posedge TCK) disable iff (!tck_rst_n)
    (st_r == tap_pkg::SH_DR && sel_bsr) |=> (bsr_sh_r[BSR_W-1] == $past(TDI))
      && (bsr_sh_r[BSR_W-2:0] == $past(bsr_sh_r[BSR_W-1:1]))
  ) else $error("Boundary register shift order wrong");

  chk_bypass_path: assert property ( // see R05, R06, R07
    @(posedge TCK) disable iff (!tck_rst_n)
    (st_r == tap_pkg::SH_DR && !sel_bsr && !sel_id) |=> (byp_r == $past(TDI)) ##0 (tdo_mux == byp_r)
  ) else $error("Bypass bit not on the serial path");

  chk_scan_drive: assert property ( // see R02, R05
    @(posedge CLK) disable iff (!RST_N)
    (mode_c_r == tap_pkg::PAD_SCAN) |=> (BALL_O == $past(upd_c_r)) && (BALL_OE_N == '0)
  ) else $error("Balls not driven from boundary cells");

  chk_highz_float: assert property ( // see R06
    @(posedge CLK) disable iff (!RST_N)
    (mode_c_r == tap_pkg::PAD_HIZ) |=> (BALL_OE_N == '1)
  ) else $error("Balls not floated under HIGH-Z");

  chk_func_pass: assert property ( // see R03, R04, R07
    @(posedge CLK) disable iff (!RST_N)
    (mode_c_r == tap_pkg::PAD_FUNC) |=> (BALL_O == $past(CORE_O)) && (BALL_OE_N == $past(CORE_OE_N))
  ) else $error("Normal ball path disturbed");

  chk_mode_follow: assert property ( // see R02, R06
    @(posedge CLK) disable iff (!RST_N)
    $rose(tg2_r ^ tg3_r) |=> (mode_c_r == $past(mode_t_r))
  ) else $error("Pad mode not taken over after crossing");

endmodule

// file: core/tap_pkg.sv
// Constants and types of the boundary-scan test port.
// Assumes two includers, the test port module and its testbench, and 1149.1 style pin timing.
package tap_pkg;
  localparam int         IR_W       = 8;
  localparam int         BSR_W      = 113;
  localparam int         ID_W       = 32;
  localparam logic [7:0] OP_EXTEST  = 8'h00;
  localparam logic [7:0] OP_IDCODE  = 8'h21;
  localparam logic [7:0] OP_SAMPLE  = 8'h05;
  localparam logic [7:0] OP_CLAMP   = 8'h07;
  localparam logic [7:0] OP_HIGHZ   = 8'h03;
  localparam logic [7:0] OP_BYPASS  = 8'hff;
  localparam logic [1:0] IR_CAP_LSB = 2'h1;
  localparam logic [5:0] IR_CAP_MSB = 6'h00;
  // Arbitrary neutral identity value; bit 0 marks an ID register
  localparam logic [31:0] ID_DEFAULT = 32'h0a5a_5001;
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } tap_st_t;
  typedef enum logic [1:0] {
    PAD_FUNC, PAD_SCAN, PAD_HIZ
  } pad_mode_t;
endpackage

// file: verif/boundary_scan_tap_instructions_tb.sv
// Testbench of the boundary-scan port: tester model on the link, bench on the ball side.
// Assumes the pad crossing settles within 8 CLK after the TCK update edge.
module boundary_scan_tap_instructions_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int           N  = tap_pkg::BSR_W;
  localparam logic [127:0] PA = {4{32'h3c5a_96e1}};
  localparam logic [127:0] PB = {4{32'h0f1e_2d4b}};
  localparam logic [127:0] PC = {4{32'h6b27_d8c4}};
  logic           clk;
  logic           rst_n;
  wire logic      tck;
  wire logic      tms;
  wire logic      tdi;
  wire logic      tdo;
  wire logic      tdo_oe_n;
  wire logic      tdo_pin;
  logic [N-1:0]   ball_i;
  logic [N-1:0]   core_o;
  logic [N-1:0]   core_oe_n;
  wire  [N-1:0]   ball_o;
  wire  [N-1:0]   ball_oe_n;
  logic [127:0]   q;
  logic           b;
  int             n_fail = 0;
  int             samples_checked = 0;

  scan_tap dut (.CLK(clk), .RST_N(rst_n), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE_N(tdo_oe_n),
                .BALL_I(ball_i), .CORE_O(core_o), .CORE_OE_N(core_oe_n), .BALL_O(ball_o), .BALL_OE_N(ball_oe_n));
  // Released TDO reads as the pull-up level, so a missing enable corrupts the data
  assign tdo_pin = tdo_oe_n ? 1'b1 : tdo;
  scan_master tester (.TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo_pin));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Only the six defined codes are ever loaded
  task automatic load_ir(input logic [7:0] code);
    tester.scan(1'b1, 8, code, q);
    chk("ir capture", q[7:0], 8'h01);
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic chk_func();
    chk("ball out", ball_o, core_o);
    chk("ball oe", ball_oe_n, core_oe_n);
  endtask
  task automatic t_idcode();
    tester.scan(1'b0, 32, '0, q);
    chk("idcode", q[31:0], tap_pkg::ID_DEFAULT);
    chk_func();
  endtask
  task automatic t_bypass(input logic [7:0] code);
    load_ir(code);
    tester.scan(1'b0, 2, 128'h3, q);
    chk("bypass path", q[1:0], 2'b10);
  endtask
  task automatic t_sample();
    ball_i = PA[N-1:0];
    load_ir(tap_pkg::OP_SAMPLE);
    tester.scan(1'b0, N, PB, q);
    chk("sample capture", q[N-1:0], PA[N-1:0]);
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk_func();
  endtask
  task automatic t_extest();
    load_ir(tap_pkg::OP_EXTEST);
    chk("preload drive", ball_o, PB[N-1:0]);
    chk("extest oe", ball_oe_n, {N{1'b0}});
    ball_i = PC[N-1:0];
    tester.scan(1'b0, N, PA, q);
    chk("extest capture", q[N-1:0], PC[N-1:0]);
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk("extest drive", ball_o, PA[N-1:0]);
  endtask
  task automatic t_tlr();
    tester.tick(1'b1, 1'b0, b);
    tester.tick(1'b0, 1'b0, b);
    tester.tick(1'b0, 1'b0, b);
    @(negedge clk);
    chk("shift oe", tdo_oe_n, 1'b0);
    repeat (5) tester.tick(1'b1, 1'b0, b);
    chk("idle oe", tdo_oe_n, 1'b1);
    tester.tick(1'b0, 1'b1, b);
    repeat (8) @(posedge clk);
    @(negedge clk);
    t_idcode();
  endtask

  initial begin
    rst_n = 1'b0;
    ball_i = '0;
    core_o = PC[N-1:0];
    core_oe_n = PA[N-1:0];
    repeat (2) @(negedge clk);
    // Reset also spans one TCK edge so the test-clock side is cleared
    tester.tick(1'b1, 1'b0, b);
    chk("reset oe", ball_oe_n, {N{1'b1}});
    @(negedge clk);
    rst_n = 1'b1;
    repeat (3) tester.tick(1'b1, 1'b0, b);
    tester.tick(1'b0, 1'b1, b);
    t_idcode();
    t_sample();
    t_extest();
    t_bypass(tap_pkg::OP_CLAMP);
    chk("clamp drive", ball_o, PA[N-1:0]);
    chk("clamp oe", ball_oe_n, {N{1'b0}});
    t_bypass(tap_pkg::OP_HIGHZ);
    chk("highz oe", ball_oe_n, {N{1'b1}});
    t_bypass(tap_pkg::OP_BYPASS);
    chk_func();
    t_bypass(tap_pkg::OP_HIGHZ);
    t_tlr();
    results();
  end
endmodule

// file: verif/scan_master.sv
// Board tester model: drives the serial test link.
// Assumes TMS/TDI sampled on rising TCK, TDO moved on falling TCK; TCK stands still between frames.
module scan_master (
  output logic      TCK,
  output logic      TMS,
  output logic      TDI,
  input  wire logic TDO
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    TCK = 1'b0;
    TMS = 1'b1;
    TDI = 1'b0;
  end
  // One 125 ns period; TDO is taken just before the rising edge
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    TMS = tms;
    TDI = tdi;
    #62.5;
    tdo = TDO;
    TCK = 1'b1;
    #62.5;
    TCK = 1'b0;
  endtask
  // Run-Test-Idle, one IR or DR scan LSB first, Update, back to idle.
  // Outside the shift TDI toggles so a stale bit can never pass as data.
  task automatic scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
    logic t;
    dout = '0;
    tick(1'b1, ~TDI, t);
    if (ir) begin
      tick(1'b1, ~TDI, t);
    end
    tick(1'b0, ~TDI, t);
    tick(1'b0, ~TDI, t);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], t);
      dout[i] = t;
    end
    tick(1'b1, ~TDI, t);
    tick(1'b0, ~TDI, t);
  endtask
endmodule
